// [hdl/boot_hex_resp.sv]
// Error replies, byte checksum and binary record parser
`timescale 1ns/1ps
module boot_hex_resp
  import boot_hex_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Receiver
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_frame_err_in,
  input wire logic rx_overrun_err_in,
  // Command context
  input wire logic cmd_invalid_in,
  input wire logic pwd_fail_in,
  input wire logic hex_start_in,
  input wire sum_kind_t sum_kind_in,
  // Checksum source
  input wire logic sum_clear_in,
  input wire logic sum_add_in,
  input wire logic [15:0] sum_addr_in,
  input wire logic [7:0] sum_byte_in,
  input wire logic [15:0] sum_lo_in,
  input wire logic [15:0] sum_hi_in,
  input wire logic sum_send_in,
  input wire logic sum_flag_en_in,
  input wire logic ovw_flag_in,
  // Transmitter
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  // Record output
  output logic rec_wr_valid_out,
  output logic [15:0] rec_wr_addr_out,
  output logic [15:0] rec_wr_seg_out,
  output logic [7:0] rec_wr_data_out,
  output logic hex_end_out,
  output logic [15:0] sum_out,
  output logic idle_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_win(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  parse_state_t pstate_reg;
  logic halted_reg;
  logic [7:0] len_reg;
  logic [7:0] cnt_reg;
  logic [15:0] off_reg;
  logic [7:0] type_reg;
  logic [7:0] rsum_reg;
  logic [15:0] seg_reg;
  logic [15:0] seg_tmp_reg;
  logic [15:0] sum_reg;
  logic [1:0] tx_left_reg;
  logic [15:0] tx_q_reg;
  logic tx_err_reg;
  logic rx_ok;
  logic rx_err;
  logic parsing;
  logic fmt_err;
  logic parse_kill;
  logic tx_accept;
  logic tx_free;
  logic err_go;
  logic sum_go;
  logic err_done;
  logic [7:0] err_code;
  logic ext_add;
  logic ram_add;
  logic [15:0] sum_next;
  logic [7:0] rsum_next;

  assign rx_ok = rx_valid_in && !halted_reg;
  assign rx_err = (rx_frame_err_in || rx_overrun_err_in) && !halted_reg;
  assign parsing = (pstate_reg != P_OFF);
  assign tx_accept = tx_valid_out && tx_ready_in;
  assign tx_free = (tx_left_reg == NONE_LEFT) && !halted_reg;
  assign rsum_next = rsum_reg + rx_data_in;

  // ----------------------------------------------------------------
  // Format checks
  // ----------------------------------------------------------------
  always_comb
  begin
    fmt_err = 1'b0;
    if (rx_ok)
    begin
      unique case (pstate_reg)
        P_TYPE:
        begin
          if (rx_data_in > TYPE_EXT)
            fmt_err = 1'b1;
          if (rx_data_in == TYPE_EXT && len_reg != EXT_LEN)
            fmt_err = 1'b1;
          if (rx_data_in == TYPE_EXT && off_reg != EXT_OFFSET)
            fmt_err = 1'b1;
          if (rx_data_in == TYPE_END && len_reg != END_LEN)
            fmt_err = 1'b1;
          if (rx_data_in == TYPE_DATA && seg_reg > SEG_LIMIT)
            fmt_err = 1'b1;
          if (rx_data_in == TYPE_DATA && len_reg == ZERO_BYTE)
            fmt_err = 1'b1;
        end
        P_CSUM:
          fmt_err = (rsum_next != ZERO_BYTE);
        P_OFF, P_MARK, P_LEN, P_OFFH, P_OFFL, P_DATA:
          fmt_err = 1'b0;
      endcase
    end
  end

  assign parse_kill = parsing && (rx_err || fmt_err);

  // ----------------------------------------------------------------
  // Record parser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pstate_reg <= P_OFF;
      len_reg <= ZERO_BYTE;
      cnt_reg <= ZERO_BYTE;
      off_reg <= EXT_OFFSET;
      type_reg <= ZERO_BYTE;
      rsum_reg <= ZERO_BYTE;
    end
    else if (halted_reg || parse_kill)
      pstate_reg <= P_OFF;
    else if (!parsing)
    begin
      if (hex_start_in)
        pstate_reg <= P_MARK;
    end
    else if (rx_ok)
    begin
      unique case (pstate_reg)
        P_MARK:
        begin
          if (rx_data_in == REC_MARK)
          begin
            pstate_reg <= P_LEN;
            rsum_reg <= ZERO_BYTE;
          end
        end
        P_LEN:
        begin
          len_reg <= rx_data_in;
          rsum_reg <= rsum_next;
          pstate_reg <= P_OFFH;
        end
        P_OFFH:
        begin
          off_reg <= {rx_data_in, off_reg[7:0]};
          rsum_reg <= rsum_next;
          pstate_reg <= P_OFFL;
        end
        P_OFFL:
        begin
          off_reg <= {off_reg[15:8], rx_data_in};
          rsum_reg <= rsum_next;
          pstate_reg <= P_TYPE;
        end
        P_TYPE:
        begin
          type_reg <= rx_data_in;
          rsum_reg <= rsum_next;
          cnt_reg <= ZERO_BYTE;
          pstate_reg <= (len_reg == ZERO_BYTE) ? P_CSUM : P_DATA;
        end
        P_DATA:
        begin
          rsum_reg <= rsum_next;
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg + 8'h01 == len_reg)
            pstate_reg <= P_CSUM;
        end
        P_CSUM:
          pstate_reg <= (type_reg == TYPE_END) ? P_OFF : P_MARK;
        P_OFF:
          pstate_reg <= P_OFF;
      endcase
    end
  end

  // Segment from extended records, taken once the record checks out
  assign ext_add = rx_ok && pstate_reg == P_DATA && type_reg == TYPE_EXT;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      seg_reg <= EXT_OFFSET;
      seg_tmp_reg <= EXT_OFFSET;
    end
    else if (!parsing && hex_start_in)
      seg_reg <= EXT_OFFSET;
    else if (ext_add)
      seg_tmp_reg <= {seg_tmp_reg[7:0], rx_data_in};
    else if (rx_ok && pstate_reg == P_CSUM && !fmt_err
             && type_reg == TYPE_EXT)
      seg_reg <= seg_tmp_reg;
  end

  // Record data output
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rec_wr_valid_out <= 1'b0;
      rec_wr_addr_out <= EXT_OFFSET;
      rec_wr_seg_out <= EXT_OFFSET;
      rec_wr_data_out <= ZERO_BYTE;
      hex_end_out <= 1'b0;
    end
    else
    begin
      rec_wr_valid_out <= !parse_kill && rx_ok && pstate_reg == P_DATA
                          && type_reg == TYPE_DATA;
      rec_wr_addr_out <= off_reg + {8'h00, cnt_reg};
      rec_wr_seg_out <= seg_reg;
      rec_wr_data_out <= rx_data_in;
      hex_end_out <= rx_ok && pstate_reg == P_CSUM && !fmt_err
                     && type_reg == TYPE_END;
    end
  end

  // ----------------------------------------------------------------
  // Checksum accumulator
  // ----------------------------------------------------------------
  assign ram_add = rx_ok && !parse_kill && pstate_reg == P_DATA
                   && type_reg == TYPE_DATA && sum_kind_in == SUM_RAM;

  always_comb
  begin
    sum_next = sum_reg;
    if (sum_add_in)
    begin
      unique case (sum_kind_in)
        SUM_ERASE, SUM_READ:
          if (in_win(sum_addr_in, sum_lo_in, sum_hi_in))
            sum_next = sum_next + {8'h00, sum_byte_in};
        SUM_FLASH:
          if (in_win(sum_addr_in, FLASH_LO, FLASH_HI))
            sum_next = sum_next + {8'h00, sum_byte_in};
        SUM_ID:
          if (in_win(sum_addr_in, ID_FIRST, ID_LAST))
            sum_next = sum_next + {8'h00, sum_byte_in};
        SUM_STATUS:
          if (in_win(sum_addr_in, ST_FIRST, ST_LAST))
            sum_next = sum_next + {8'h00, sum_byte_in};
        default:
          sum_next = sum_reg;
      endcase
    end
    if (ram_add)
      sum_next = sum_next + {8'h00, rx_data_in};
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sum_reg <= SUM_RESET;
    else if (sum_clear_in)
      sum_reg <= SUM_RESET;
    else
      sum_reg <= sum_next;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sum_out <= SUM_RESET;
    else
      sum_out <= sum_reg;
  end

  // ----------------------------------------------------------------
  // Reply transmitter
  // ----------------------------------------------------------------
  assign err_go = tx_free && !parsing && (rx_err || cmd_invalid_in);
  assign sum_go = tx_free && !parsing && !err_go && sum_send_in;
  assign err_done = tx_accept && tx_err_reg && tx_left_reg == LAST_LEFT;

  always_comb
  begin
    if (rx_frame_err_in)
      err_code = ERR_FRAME;
    else if (rx_overrun_err_in)
      err_code = ERR_OVERRUN;
    else
      err_code = ERR_CMD;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tx_left_reg <= NONE_LEFT;
      tx_q_reg <= SUM_RESET;
      tx_err_reg <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_data_out <= ZERO_BYTE;
    end
    else if (err_go)
    begin
      tx_left_reg <= ERR_REPEAT;
      tx_q_reg <= {err_code, err_code};
      tx_err_reg <= 1'b1;
      tx_valid_out <= 1'b1;
      tx_data_out <= err_code;
    end
    else if (sum_go)
    begin
      tx_err_reg <= 1'b0;
      tx_valid_out <= 1'b1;
      if (sum_flag_en_in)
      begin
        tx_left_reg <= WR_REPLY_LEN;
        tx_q_reg <= sum_reg;
        tx_data_out <= {7'h00, ovw_flag_in};
      end
      else
      begin
        tx_left_reg <= SUM_REPLY_LEN;
        tx_q_reg <= {sum_reg[7:0], ZERO_BYTE};
        tx_data_out <= sum_reg[15:8];
      end
    end
    else if (tx_accept)
    begin
      tx_left_reg <= tx_left_reg - LAST_LEFT;
      tx_valid_out <= (tx_left_reg != LAST_LEFT);
      tx_data_out <= tx_q_reg[15:8];
      tx_q_reg <= {tx_q_reg[7:0], ZERO_BYTE};
    end
  end

  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      halted_reg <= 1'b0;
    else if (err_done)
      halted_reg <= 1'b1;
    else if (pwd_fail_in && tx_free)
      halted_reg <= 1'b1;
    else if (parse_kill)
      halted_reg <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      idle_out <= 1'b0;
    else
      idle_out <= halted_reg || err_done || parse_kill
                  || (pwd_fail_in && tx_free);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_ERR_REPEAT: assert property (
    tx_accept && tx_err_reg && tx_left_reg > LAST_LEFT
    |=> tx_valid_out && tx_data_out == $past(tx_data_out))
    else $error("error code byte changed");
  AST_ERR_IDLE: assert property (
    err_done |=> halted_reg && !tx_valid_out ##1 !tx_valid_out[*3])
    else $error("not idle after error code");
  AST_PWD_SILENT: assert property (
    pwd_fail_in && tx_free |=> halted_reg && !tx_valid_out[*4])
    else $error("reply after password failure");
  AST_SUM_HIGH: assert property (
    sum_go && !sum_flag_en_in && !tx_ready_in
    |=> tx_data_out == $past(sum_reg[15:8]) && tx_left_reg == SUM_REPLY_LEN)
    else $error("checksum high byte wrong");
  AST_SUM_FLASH: assert property (
    sum_add_in && sum_kind_in == SUM_FLASH && !sum_clear_in
    && sum_addr_in < FLASH_LO |=> sum_reg == $past(sum_reg))
    else $error("byte outside flash summed");
  AST_MARK_DISCARD: assert property (
    pstate_reg == P_MARK && rx_ok && rx_data_in != REC_MARK
    && !rx_err |=> pstate_reg == P_MARK && !rec_wr_valid_out)
    else $error("byte taken while waiting for mark");
  AST_PARSE_QUIET: assert property (
    parsing && rx_err && tx_free |=> halted_reg ##0 !tx_valid_out[*3])
    else $error("code sent on record error");
  AST_BAD_TYPE: assert property (
    pstate_reg == P_TYPE && rx_ok && rx_data_in > TYPE_EXT
    |=> halted_reg && pstate_reg == P_OFF)
    else $error("bad record type accepted");
  AST_BAD_CSUM: assert property (
    pstate_reg == P_CSUM && rx_ok && rsum_next != ZERO_BYTE
    |=> halted_reg && !hex_end_out)
    else $error("bad record checksum accepted");
  AST_END_LEN: assert property (
    pstate_reg == P_TYPE && rx_ok && rx_data_in == TYPE_END
    && len_reg != END_LEN |=> halted_reg)
    else $error("end record length accepted");

endmodule

// [hdl/boot_hex_pkg.sv]
// Constants and types for the boot serial error, sum and record block
package boot_hex_pkg;

  // ----------------------------------------------------------------
  // Reply codes and record bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_CMD = 8'h63;
  localparam logic [7:0] ERR_FRAME = 8'hA1;
  localparam logic [7:0] ERR_OVERRUN = 8'hA3;
  localparam logic [7:0] REC_MARK = 8'h3A;
  localparam logic [7:0] TYPE_DATA = 8'h00;
  localparam logic [7:0] TYPE_END = 8'h01;
  localparam logic [7:0] TYPE_EXT = 8'h02;
  localparam logic [7:0] EXT_LEN = 8'h02;
  localparam logic [7:0] END_LEN = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] EXT_OFFSET = 16'h0000;
  localparam logic [15:0] SEG_LIMIT = 16'h2000;

  // ----------------------------------------------------------------
  // Checksum windows
  // ----------------------------------------------------------------
  localparam logic [15:0] FLASH_LO = 16'hC000;
  localparam logic [15:0] FLASH_HI = 16'hFFFF;
  localparam logic [15:0] ID_FIRST = 16'h0009;
  localparam logic [15:0] ID_LAST = 16'h0012;
  localparam logic [15:0] ST_FIRST = 16'h0009;
  localparam logic [15:0] ST_LAST = 16'h000C;
  localparam logic [15:0] SUM_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Reply lengths
  // ----------------------------------------------------------------
  localparam logic [1:0] ERR_REPEAT = 2'h3;
  localparam logic [1:0] SUM_REPLY_LEN = 2'h2;
  localparam logic [1:0] WR_REPLY_LEN = 2'h3;
  localparam logic [1:0] LAST_LEFT = 2'h1;
  localparam logic [1:0] NONE_LEFT = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SUM_ERASE = 3'h0,
    SUM_FLASH = 3'h1,
    SUM_READ = 3'h2,
    SUM_RAM = 3'h3,
    SUM_ID = 3'h4,
    SUM_STATUS = 3'h5
  } sum_kind_t;

  typedef enum logic [7:0] {
    P_OFF = 8'h01,
    P_MARK = 8'h02,
    P_LEN = 8'h04,
    P_OFFH = 8'h08,
    P_OFFL = 8'h10,
    P_TYPE = 8'h20,
    P_DATA = 8'h40,
    P_CSUM = 8'h80
  } parse_state_t;

endpackage

// [testbench/prog_ctl_model.sv]
// Programming controller model on the far side of the serial link
`timescale 1ns/1ps
module prog_ctl_model (
  // Clock
  input wire logic clk_in,
  // Bytes toward the block
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  // Bytes from the block
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];
  int stall = 0;
  int pseed = 55;

  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b1;
  end

  // ----------------------------------------------------------------
  // Raw binary byte, data line inverted once released
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    @(negedge clk_in);
    rx_valid_out = 1'b1;
    rx_data_out = b;
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_data_out = ~b;
  endtask

  // Acceptance with optional random stalls
  always @(negedge clk_in)
    tx_ready_out <= (stall != 0) ? 1'($random(pseed)) : 1'b1;

  always @(posedge clk_in)
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1)
      got.push_back(tx_data_in);
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the error, sum and record block
`timescale 1ns/1ps
module tb_top;
  import boot_hex_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rx_valid_in, rx_frame_err_in, rx_overrun_err_in, cmd_invalid_in;
  logic pwd_fail_in, hex_start_in, sum_clear_in, sum_add_in, sum_send_in;
  logic sum_flag_en_in, ovw_flag_in, tx_ready_in, tx_valid_out;
  logic rec_wr_valid_out, hex_end_out, idle_out;
  logic [7:0] rx_data_in, sum_byte_in, tx_data_out, rec_wr_data_out;
  logic [15:0] sum_addr_in, sum_lo_in, sum_hi_in, sum_out;
  logic [15:0] rec_wr_addr_out, rec_wr_seg_out;
  sum_kind_t sum_kind_in;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 55;
  int cyc = 0;
  int n_end = 0;
  logic [39:0] wq[$];

  always #2.5 clk_in = ~clk_in;

  boot_hex_resp dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
    .rx_frame_err_in(rx_frame_err_in), .rx_overrun_err_in(rx_overrun_err_in),
    .cmd_invalid_in(cmd_invalid_in), .pwd_fail_in(pwd_fail_in),
    .hex_start_in(hex_start_in), .sum_kind_in(sum_kind_in),
    .sum_clear_in(sum_clear_in), .sum_add_in(sum_add_in),
    .sum_addr_in(sum_addr_in), .sum_byte_in(sum_byte_in),
    .sum_lo_in(sum_lo_in), .sum_hi_in(sum_hi_in),
    .sum_send_in(sum_send_in), .sum_flag_en_in(sum_flag_en_in),
    .ovw_flag_in(ovw_flag_in), .tx_ready_in(tx_ready_in),
    .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .rec_wr_valid_out(rec_wr_valid_out), .rec_wr_addr_out(rec_wr_addr_out),
    .rec_wr_seg_out(rec_wr_seg_out), .rec_wr_data_out(rec_wr_data_out),
    .hex_end_out(hex_end_out), .sum_out(sum_out), .idle_out(idle_out));

  prog_ctl_model ctl (.clk_in(clk_in), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic int rnd(input int n);
    return {$random(seed)} % n;
  endfunction

  function automatic bit in_win(sum_kind_t k, int a, int lo, int hi);
    case (k)
      SUM_FLASH: return a >= 'hC000;
      SUM_ID: return a >= 9 && a <= 18;
      SUM_STATUS: return a >= 9 && a <= 12;
      default: return a >= lo && a <= hi;
    endcase
  endfunction

  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
  endtask

  task automatic do_reset;
    @(negedge clk_in);
    nrst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    nrst_in = 1'b1;
    ctl.got.delete();
    wq.delete();
    n_end = 0;
  endtask

  task automatic wait_n(input int n);
    int k;
    for (k = 0; k < 400 && ctl.got.size() < n; k++)
      @(negedge clk_in);
    repeat (6) @(negedge clk_in);
  endtask

  task automatic reply(input bit fl, input logic [15:0] s);
    int n;
    n = fl ? 3 : 2;
    ovw_flag_in = 1'(rnd(2));
    sum_flag_en_in = fl;
    ctl.got.delete();
    pulse(sum_send_in);
    wait_n(n);
    chk(ctl.got.size(), n);
    if (fl)
      chk(ctl.got[0], ovw_flag_in);
    chk(ctl.got[n - 2], s[15:8]);
    chk(ctl.got[n - 1], s[7:0]);
  endtask

  task automatic send_rec(input logic [15:0] off, input logic [7:0] typ,
    input logic [7:0] p[$], input bit bad);
    logic [7:0] cs;
    cs = 8'(p.size()) + off[15:8] + off[7:0] + typ;
    foreach (p[i])
      cs += p[i];
    cs = (~cs + 8'h01) ^ {7'h00, bad};
    ctl.send(8'h3A);
    ctl.send(8'(p.size()));
    ctl.send(off[15:8]);
    ctl.send(off[7:0]);
    ctl.send(typ);
    foreach (p[i])
      ctl.send(p[i]);
    ctl.send(cs);
  endtask

  // Record writes and end events seen at the ports
  always @(posedge clk_in)
  begin
    if (rec_wr_valid_out === 1'b1)
      wq.push_back({rec_wr_seg_out, rec_wr_addr_out, rec_wr_data_out});
    if (hex_end_out === 1'b1)
      n_end++;
  end

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sum_kind_t kinds[5];
    logic [7:0] code[3];
    logic [7:0] p[$];
    logic [39:0] ex[$];
    logic [15:0] seg, off;
    int i, k, a, b, s, lo, hi, n;
    kinds = '{SUM_FLASH, SUM_ERASE, SUM_READ, SUM_ID, SUM_STATUS};
    code = '{8'hA1, 8'hA3, 8'h63};
    {rx_frame_err_in, rx_overrun_err_in, cmd_invalid_in, pwd_fail_in} = 4'h0;
    {hex_start_in, sum_clear_in, sum_add_in, sum_send_in} = 4'h0;
    {sum_flag_en_in, ovw_flag_in} = 2'h0;
    {sum_addr_in, sum_lo_in, sum_hi_in} = 48'h0;
    sum_byte_in = 8'h00;
    sum_kind_in = SUM_FLASH;
    // Windowed byte sums for every kind except SUM_RAM
    for (i = 0; i < 5; i++)
    begin
      do_reset();
      sum_kind_in = kinds[i];
      lo = rnd(65536);
      hi = lo + rnd(65536 - lo);
      sum_lo_in = 16'(lo);
      sum_hi_in = 16'(hi);
      ctl.stall = i % 2;
      pulse(sum_clear_in);
      s = 0;
      for (k = 0; k < 60; k++)
      begin
        a = i > 2 ? rnd(21) : rnd(65536);
        b = rnd(256);
        if (in_win(kinds[i], a, lo, hi))
          s += b;
        @(negedge clk_in);
        sum_add_in = 1'b1;
        sum_addr_in = 16'(a);
        sum_byte_in = 8'(b);
      end
      @(negedge clk_in);
      sum_add_in = 1'b0;
      repeat (3) @(negedge clk_in);
      chk(sum_out, s[15:0]);
      reply(i == 0, s[15:0]);
    end
    $display("Test sums done");
    // Records with garbage, large record, segment at limit
    do_reset();
    sum_kind_in = SUM_RAM;
    ctl.stall = 1;
    pulse(sum_clear_in);
    pulse(hex_start_in);
    seg = 16'h0000;
    s = 0;
    ex.delete();
    for (i = 0; i < 3; i++)
    begin
      ctl.send(8'h11);
      ctl.send(8'(rnd(58)));
      p.delete();
      n = i == 1 ? 255 : 1 + rnd(8);
      off = 16'(rnd(65536));
      for (k = 0; k < n; k++)
      begin
        p.push_back(8'(rnd(256)));
        ex.push_back({seg, 16'(off + k), p[k]});
        s += p[k];
      end
      send_rec(off, TYPE_DATA, p, 1'b0);
      if (i == 0)
      begin
        p = '{8'h20, 8'h00};
        send_rec(16'h0000, TYPE_EXT, p, 1'b0);
        seg = 16'h2000;
      end
    end
    p.delete();
    send_rec(16'h0000, TYPE_END, p, 1'b0);
    repeat (6) @(negedge clk_in);
    chk(n_end, 1);
    chk(wq.size(), ex.size());
    foreach (ex[k])
      chk(wq[k], ex[k]);
    reply(1'b0, s[15:0]);
    $display("Test records done");
    // Format and receive errors in records stop silently
    for (i = 0; i < 7; i++)
    begin
      do_reset();
      pulse(hex_start_in);
      p = '{8'h01, 8'h02};
      case (i)
        0: send_rec(16'h0000, 8'h03, p, 1'b0);
        1: send_rec(16'h0100, TYPE_DATA, p, 1'b1);
        2:
        begin
          p.push_back(8'h03);
          send_rec(16'h0000, TYPE_EXT, p, 1'b0);
        end
        3:
        begin
          p = '{8'h20, 8'h01};
          send_rec(16'h0000, TYPE_EXT, p, 1'b0);
          send_rec(16'h0010, TYPE_DATA, p, 1'b0);
        end
        4:
        begin
          p = '{8'h05};
          send_rec(16'h0000, TYPE_END, p, 1'b0);
        end
        5: send_rec(16'h0001, TYPE_EXT, p, 1'b0);
        default:
        begin
          ctl.send(8'h3A);
          pulse(rx_frame_err_in);
        end
      endcase
      repeat (6) @(negedge clk_in);
      chk(idle_out, 1'b1);
      pulse(sum_send_in);
      repeat (6) @(negedge clk_in);
      chk(ctl.got.size(), 0);
    end
    $display("Test format errors done");
    // Error codes and silent password failure
    for (i = 0; i < 4; i++)
    begin
      do_reset();
      ctl.stall = 1;
      case (i)
        0: pulse(rx_frame_err_in);
        1: pulse(rx_overrun_err_in);
        2: pulse(cmd_invalid_in);
        default: pulse(pwd_fail_in);
      endcase
      n = i < 3 ? 3 : 0;
      wait_n(n);
      pulse(cmd_invalid_in);
      repeat (6) @(negedge clk_in);
      chk(ctl.got.size(), n);
      for (k = 0; k < n; k++)
        chk(ctl.got[k], code[i]);
      chk(idle_out, 1'b1);
    end
    $display("Test error codes done");
    tally_and_finish();
  end
endmodule
